// ### rtl/tlb_mgmt_pkg.sv
// Package: offsets, field layouts and constants of the translation buffer registers
package tlb_mgmt_pkg;
  localparam int          ENTRY_COUNT   = 48;
  localparam logic [5:0]  TOP_ENTRY     = 6'h2F;
  localparam logic [5:0]  PINNED_RESET  = 6'h00;
  localparam int          IDX_W         = 6;
  // Register offsets on the plain port (word index, four-byte stride)
  localparam logic [2:0]  REG_ENTRY_SEL = 3'h0;
  localparam logic [2:0]  REG_REPLACE   = 3'h1;
  localparam logic [2:0]  REG_EVEN_LO   = 3'h2;
  localparam logic [2:0]  REG_ODD_LO    = 3'h3;
  localparam logic [2:0]  REG_PAGE_MASK = 3'h5;
  localparam logic [2:0]  REG_PINNED    = 3'h6;
  localparam logic [2:0]  REG_CTRL      = 3'h7;
  // Field positions
  localparam int          PROBE_FAIL_BIT = 31;
  localparam int          MASK_LSB       = 13;
  localparam int          MASK_W         = 12;
  localparam int          LO_W           = 30;
  localparam int          GLOBAL_BIT     = 0;
  localparam int          VALID_BIT      = 1;
  // Control register write bits (pulses)
  localparam int          CMD_PROBE      = 0;
  localparam int          CMD_READ       = 1;
  localparam int          CMD_WR_INDEX   = 2;
  localparam int          CMD_WR_RANDOM  = 3;
  // Bus carrier
  typedef struct packed {
    logic [2:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_type;
  // One buffer entry as held in the array
  typedef struct packed {
    logic [MASK_W-1:0] mask;
    logic [26:0]       vpn2;
    logic [7:0]        tag;
    logic [LO_W-1:0]   even_lo;
    logic [LO_W-1:0]   odd_lo;
  } entry_type;
endpackage

// ### rtl/tlb_mgmt.sv
// Translation buffer management registers with entry array and lookup
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE1 - Six-bit select names entry for read/write
// RULE2 - Top select bit flags failed probe
// RULE3 - Successful probe loads matching entry number
// RULE4 - Select values above 47 match nothing
// RULE5 - Reserved bits read zero; software writes zero
// RULE6 - Replacement pointer read-only, decrements each instruction
// RULE7 - Pointer stays between pinned limit and 47
// RULE8 - Random write uses current replacement pointer
// RULE9 - Reset loads pointer with upper bound
// RULE10 - Pinned limit write reloads pointer top
// RULE11 - Even and odd frame registers, same layout
// RULE12 - Mask selects compared address bits 24:13
// RULE13 - Seven legal masks, paired ones from 13
// RULE14 - Software loads only legal mask encodings
// RULE15 - Entries below pinned limit never randomly replaced
// RULE16 - Reset clears pinned limit to zero
// RULE17 - Global in both halves ignores space tag
// RULE18 - Clear valid bit gives translation miss
// RULE19 - Pointer wraps from lower bound to top
module tlb_mgmt #(
  parameter int ENTRIES = tlb_mgmt_pkg::ENTRY_COUNT
) (
  input  wire logic                      mclk_in,
  input  wire logic                      rst_in,
  input  wire tlb_mgmt_pkg::bus_req_type bus_in,
  output logic [31:0]                    rdata_out,
  input  wire logic                      instr_retire_in,
  input  wire logic [26:0]               probe_vpn2_in,
  input  wire logic [7:0]                probe_tag_in,
  input  wire logic [26:0]               look_vpn2_in,
  input  wire logic [7:0]                look_tag_in,
  input  wire logic                      look_odd_in,
  input  wire logic                      look_req_in,
  output logic                           look_hit_out,
  output logic                           look_miss_out,
  output logic [29:0]                    look_lo_out,
  output logic [26:0]                    read_vpn2_out,
  output logic [7:0]                     read_tag_out
);
  import tlb_mgmt_pkg::*;

  // Six-bit select and fixed top entry serve only the documented depth
  if (ENTRIES != ENTRY_COUNT) begin : g_depth_check
    $error("ENTRIES must match the six-bit top");
  end

  logic [IDX_W-1:0]  entry_sel;      // Selected entry number
  logic              probe_fail;     // Last probe missed
  logic [IDX_W-1:0]  replace_ptr;    // Random replacement pointer
  logic [IDX_W-1:0]  pinned_limit;   // Lowest replaceable entry
  logic [LO_W-1:0]   even_lo;        // Even page frame staging
  logic [LO_W-1:0]   odd_lo;         // Odd page frame staging
  logic [MASK_W-1:0] page_mask;      // Page size compare mask
  entry_type         entries [ENTRIES]; // The buffer itself
  logic [ENTRIES-1:0] probe_match;   // Per-entry probe compare
  logic [ENTRIES-1:0] look_match;    // Per-entry lookup compare
  logic              wr_cycle;       // Any bus write
  logic              ctrl_wr;        // Command write
  logic              do_probe;
  logic              do_read;
  logic              do_wr_index;
  logic              do_wr_random;
  logic [IDX_W-1:0]  probe_idx;      // Encoded probe hit
  logic              probe_any;
  logic [IDX_W-1:0]  look_idx;       // Encoded lookup hit
  logic              look_any;
  entry_type         new_entry;      // Entry built from staging regs and probe inputs

  assign wr_cycle     = bus_in.wr;
  assign ctrl_wr      = wr_cycle && (bus_in.addr == REG_CTRL);
  assign do_probe     = ctrl_wr && bus_in.wdata[CMD_PROBE];
  assign do_read      = ctrl_wr && bus_in.wdata[CMD_READ];
  assign do_wr_index  = ctrl_wr && bus_in.wdata[CMD_WR_INDEX];
  assign do_wr_random = ctrl_wr && bus_in.wdata[CMD_WR_RANDOM];

  // Staging registers and the outside high half (probe inputs) form the written entry
  assign new_entry = '{mask: page_mask, vpn2: probe_vpn2_in,
                       tag: probe_tag_in, even_lo: even_lo, odd_lo: odd_lo};

  // Per-entry compare; masked bits skip, global ignores the tag
  for (genvar g = 0; g < ENTRIES; g++) begin : g_cmp
    logic [26:0] cmp_mask;
    logic        global_e;
    // RULE12 mask selects bits
    assign cmp_mask = ~{15'h0000, entries[g].mask};
    // RULE17 global ignores tag
    assign global_e = entries[g].even_lo[GLOBAL_BIT]
                    & entries[g].odd_lo[GLOBAL_BIT];
    assign probe_match[g] =
      (((entries[g].vpn2 ^ probe_vpn2_in) & cmp_mask) == 27'h0000000)
      && (global_e || entries[g].tag == probe_tag_in);
    assign look_match[g] =
      (((entries[g].vpn2 ^ look_vpn2_in) & cmp_mask) == 27'h0000000)
      && (global_e || entries[g].tag == look_tag_in);
  end

  // Priority encode matches (lowest entry wins)
  always_comb begin
    probe_idx = '0;
    probe_any = 1'b0;
    look_idx  = '0;
    look_any  = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (probe_match[i]) begin
        probe_idx = IDX_W'(i);
        probe_any = 1'b1;
      end
      if (look_match[i]) begin
        look_idx = IDX_W'(i);
        look_any = 1'b1;
      end
    end
  end

  // Entry select and probe result
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      entry_sel  <= '0;
      probe_fail <= 1'b0;
    end else if (do_probe) begin
      // RULE3 probe loads match
      entry_sel  <= probe_any ? probe_idx : entry_sel;
      // RULE2 flag failed probe
      probe_fail <= ~probe_any;
    end else if (wr_cycle && bus_in.addr == REG_ENTRY_SEL) begin
      // RULE1 software selects entry
      entry_sel  <= bus_in.wdata[IDX_W-1:0];
    end
  end

  // Pinned limit register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      // RULE16 reset clears limit
      pinned_limit <= PINNED_RESET;
    end else if (wr_cycle && bus_in.addr == REG_PINNED) begin
      pinned_limit <= bus_in.wdata[IDX_W-1:0];
    end
  end

  // Replacement pointer, decremented per retired instruction
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      // RULE9 reset loads top
      replace_ptr <= TOP_ENTRY;
    end else if (wr_cycle && bus_in.addr == REG_PINNED) begin
      // RULE10 limit write reloads
      replace_ptr <= TOP_ENTRY;
    end else if (instr_retire_in) begin
      // RULE7 RULE19 wrap at bound
      if (replace_ptr <= pinned_limit || replace_ptr > TOP_ENTRY) begin
        replace_ptr <= TOP_ENTRY;
      end else begin
        // RULE6 decrement per instruction
        replace_ptr <= replace_ptr - 6'h01;
      end
    end
  end

  // Staging registers; buffer read overwrites them
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      even_lo   <= '0;
      odd_lo    <= '0;
      page_mask <= '0;
    end else if (do_read && entry_sel <= TOP_ENTRY) begin
      // RULE11 RULE12 read fills staging
      even_lo   <= entries[entry_sel].even_lo;
      odd_lo    <= entries[entry_sel].odd_lo;
      page_mask <= entries[entry_sel].mask;
    end else if (wr_cycle) begin
      // RULE11 software access
      if (bus_in.addr == REG_EVEN_LO) even_lo <= bus_in.wdata[LO_W-1:0];
      if (bus_in.addr == REG_ODD_LO)  odd_lo  <= bus_in.wdata[LO_W-1:0];
      // RULE13 RULE14 mask stored as written; illegal values are
      // the caller's hazard, translation then undefined
      if (bus_in.addr == REG_PAGE_MASK) begin
        page_mask <= bus_in.wdata[MASK_LSB +: MASK_W];
      end
    end
  end

  // High half of a read entry goes to the outside high register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      read_vpn2_out <= '0;
      read_tag_out  <= '0;
    end else if (do_read && entry_sel <= TOP_ENTRY) begin
      read_vpn2_out <= entries[entry_sel].vpn2;
      read_tag_out  <= entries[entry_sel].tag;
    end
  end

  // Entry array writes; no reset, contents undefined at power-up
  always_ff @(posedge mclk_in) begin
    // RULE4 out of range ignored
    if (do_wr_index && entry_sel <= TOP_ENTRY) begin
      entries[entry_sel] <= new_entry;
    end
    // RULE8 RULE15 random uses pointer
    if (do_wr_random && replace_ptr >= pinned_limit
        && replace_ptr <= TOP_ENTRY) begin
      entries[replace_ptr] <= new_entry;
    end
  end

  // Lookup answer one cycle after request
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      look_hit_out  <= 1'b0;
      look_miss_out <= 1'b0;
      look_lo_out   <= '0;
    end else begin
      look_hit_out  <= 1'b0;
      look_miss_out <= 1'b0;
      if (look_req_in) begin
        if (look_any && (look_odd_in
            ? entries[look_idx].odd_lo[VALID_BIT]
            : entries[look_idx].even_lo[VALID_BIT])) begin
          look_hit_out <= 1'b1;
          look_lo_out  <= look_odd_in ? entries[look_idx].odd_lo
                                      : entries[look_idx].even_lo;
        end else begin
          // RULE18 invalid means miss
          look_miss_out <= 1'b1;
        end
      end
    end
  end

  // Read data one cycle after the strobe; reserved bits zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 32'h00000000;
    end else begin
      rdata_out <= 32'h00000000;
      if (bus_in.rd) begin
        // RULE5 reserved read zero
        unique case (bus_in.addr)
          REG_ENTRY_SEL: rdata_out <= {probe_fail, 25'h0000000, entry_sel};
          REG_REPLACE:   rdata_out <= {26'h0000000, replace_ptr};
          REG_EVEN_LO:   rdata_out <= {2'h0, even_lo};
          REG_ODD_LO:    rdata_out <= {2'h0, odd_lo};
          REG_PAGE_MASK: rdata_out <= {7'h00, page_mask, 13'h0000};
          REG_PINNED:    rdata_out <= {26'h0000000, pinned_limit};
          default:       rdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // RULE9 pointer top after reset
  AST_PTR_RESET: assert property (@(posedge mclk_in) // RULE9
    $fell(rst_in) |-> replace_ptr == TOP_ENTRY)
    else $error("pointer not at top after reset");
  // RULE7 pointer in range
  AST_PTR_RANGE: assert property (@(posedge mclk_in) // RULE7
    disable iff (rst_in)
    $past(wr_cycle && bus_in.addr == REG_PINNED) || pinned_limit > TOP_ENTRY
    || (replace_ptr >= pinned_limit && replace_ptr <= TOP_ENTRY))
    else $error("pointer out of range");
  // RULE6 decrement
  AST_PTR_DEC: assert property (@(posedge mclk_in) // RULE6
    disable iff (rst_in)
    instr_retire_in && !(wr_cycle && bus_in.addr == REG_PINNED)
    && replace_ptr > pinned_limit && replace_ptr <= TOP_ENTRY
    |=> replace_ptr == $past(replace_ptr) - 6'h01)
    else $error("pointer did not decrement");
  // RULE19 wrap
  AST_PTR_WRAP: assert property (@(posedge mclk_in) // RULE19
    disable iff (rst_in)
    instr_retire_in && replace_ptr == pinned_limit
    |=> replace_ptr == TOP_ENTRY)
    else $error("pointer did not wrap");
  // RULE10 reload on limit write
  AST_PIN_RELOAD: assert property (@(posedge mclk_in) // RULE10
    disable iff (rst_in)
    wr_cycle && bus_in.addr == REG_PINNED |=> replace_ptr == TOP_ENTRY)
    else $error("pointer not reloaded");
  // RULE2 probe failure flag
  AST_PROBE_FAIL: assert property (@(posedge mclk_in) // RULE2
    disable iff (rst_in)
    do_probe |=> probe_fail == !$past(probe_any))
    else $error("probe flag wrong");
  // RULE3 probe index
  AST_PROBE_IDX: assert property (@(posedge mclk_in) // RULE3
    disable iff (rst_in)
    do_probe && probe_any |=> entry_sel == $past(probe_idx))
    else $error("probe index wrong");
  // RULE5 reserved zero
  AST_RSVD_ZERO: assert property (@(posedge mclk_in) // RULE5
    disable iff (rst_in)
    bus_in.rd && bus_in.addr == REG_REPLACE |=> rdata_out[31:6] == '0)
    else $error("reserved bits nonzero");
  // RULE5 mask word shows its field only
  AST_MASK_FIELD: assert property (@(posedge mclk_in) // RULE5
    disable iff (rst_in)
    bus_in.rd && bus_in.addr == REG_PAGE_MASK |=>
    rdata_out[MASK_LSB-1:0] == '0 && rdata_out[31:MASK_LSB+MASK_W] == '0)
    else $error("mask word reserved bits nonzero");
  // RULE16 limit cleared
  AST_PIN_RESET: assert property (@(posedge mclk_in) // RULE16
    $fell(rst_in) |-> pinned_limit == PINNED_RESET)
    else $error("limit not cleared");
  // RULE18 no match misses
  AST_MISS: assert property (@(posedge mclk_in) // RULE18
    disable iff (rst_in)
    look_req_in && !look_any |=> look_miss_out && !look_hit_out)
    else $error("miss not reported");
  // RULE18 clear valid bit misses although the entry matches
  AST_INVALID_MISS: assert property (@(posedge mclk_in) // RULE18
    disable iff (rst_in)
    look_req_in && look_any && !(look_odd_in
      ? entries[look_idx].odd_lo[VALID_BIT]
      : entries[look_idx].even_lo[VALID_BIT])
    |=> look_miss_out && !look_hit_out)
    else $error("invalid entry not missed");
  // RULE11 buffer read fills both frame halves
  AST_READ_FILL: assert property (@(posedge mclk_in) // RULE11
    disable iff (rst_in)
    do_read && entry_sel <= TOP_ENTRY
    |=> even_lo == $past(entries[entry_sel].even_lo)
    && odd_lo == $past(entries[entry_sel].odd_lo))
    else $error("buffer read did not fill frames");
  // RULE4 read past the last entry leaves staging alone
  AST_READ_RANGE: assert property (@(posedge mclk_in) // RULE4
    disable iff (rst_in)
    do_read && entry_sel > TOP_ENTRY
    |=> even_lo == $past(even_lo) && page_mask == $past(page_mask))
    else $error("read past last entry changed staging");
  // RULE15 random write never below the limit
  AST_RANDOM_FLOOR: assert property (@(posedge mclk_in) // RULE15
    disable iff (rst_in)
    do_wr_random && pinned_limit <= TOP_ENTRY
    |-> replace_ptr >= pinned_limit)
    else $error("random write below limit");

  COV_PROBE_HIT: cover property (@(posedge mclk_in) do_probe && probe_any);
  COV_PROBE_MISS: cover property (@(posedge mclk_in) do_probe && !probe_any);
  COV_WRAP: cover property (@(posedge mclk_in)
    instr_retire_in && replace_ptr == pinned_limit);
  COV_RANDOM_WR: cover property (@(posedge mclk_in) do_wr_random);
  COV_LOOK_MISS: cover property (@(posedge mclk_in) look_req_in && !look_any);
endmodule
`default_nettype wire

// ### testbench/tlb_management_registers_bench.sv
// Self-checking bench for the translation buffer management registers
`timescale 1ns/1ns
`default_nettype none
module tlb_management_registers_bench;
  import tlb_mgmt_pkg::*;
  // About 170 clock cycles expected; generous margin before giving up
  localparam int WATCHDOG_NS = 40000;
  logic        mclk_in;     // 100 MHz clock
  logic        rst_in;      // Async reset, high
  bus_req_type bus;         // Register port request
  logic [31:0] rdata;       // Register read data
  logic        retire;      // Instruction retire pulse
  logic [26:0] probe_vpn2;  // High half page number
  logic [7:0]  probe_tag;   // High half space tag
  logic [26:0] look_vpn2;   // Lookup page number
  logic [7:0]  look_tag;    // Lookup space tag
  logic        look_odd;    // Lookup odd page select
  logic        look_req;    // Lookup request pulse
  logic        look_hit;    // Lookup hit pulse
  logic        look_miss;   // Lookup miss pulse
  logic [29:0] look_lo;     // Frame half of last hit
  logic [26:0] read_vpn2;   // Page number after buffer read
  logic [7:0]  read_tag;    // Space tag after buffer read
  int          bad_count;   // Mismatches
  int          n_tests;     // Comparisons made

  tlb_mgmt dut_u (
    .mclk_in        (mclk_in),
    .rst_in         (rst_in),
    .bus_in         (bus),
    .rdata_out      (rdata),
    .instr_retire_in(retire),
    .probe_vpn2_in  (probe_vpn2),
    .probe_tag_in   (probe_tag),
    .look_vpn2_in   (look_vpn2),
    .look_tag_in    (look_tag),
    .look_odd_in    (look_odd),
    .look_req_in    (look_req),
    .look_hit_out   (look_hit),
    .look_miss_out  (look_miss),
    .look_lo_out    (look_lo),
    .read_vpn2_out  (read_vpn2),
    .read_tag_out   (read_tag)
  );

  // Free-running clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Word compare, four-state exact
  task automatic chk_word(input string w, input logic [31:0] e,
                          input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", w, e, g);
    end
  endtask

  // Single flag compare
  task automatic chk_flag(input string w, input logic e, input logic g);
    chk_word(w, {31'h0, e}, {31'h0, g});
  endtask

  // One-cycle write strobe, dropped on the edge that takes it
  task automatic bus_wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [2:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk_in);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input string w, input logic [2:0] a,
                        input logic [31:0] e);
    logic [31:0] d;
    bus_rd(a, d);
    chk_word(w, e, d);
  endtask

  // Retire pulse held for n edges, one pointer step each (decrement, or wrap to top at the bound)
  task automatic retire_n(input int n);
    @(posedge mclk_in);
    retire <= 1'b1;
    repeat (n) @(posedge mclk_in);
    retire <= 1'b0;
  endtask

  // Lookup request; hit or miss sampled one cycle later
  task automatic lookup(input logic [26:0] v, input logic [7:0] t,
                        input logic odd);
    @(posedge mclk_in);
    look_vpn2 <= v;
    look_tag <= t;
    look_odd <= odd;
    look_req <= 1'b1;
    @(posedge mclk_in);
    look_req <= 1'b0;
    #1;
  endtask

  // Load an entry through the frame registers and an indexed write
  task automatic put_entry(input logic [5:0] i, input logic [26:0] v,
                           input logic [31:0] m);
    bus_wr(REG_PAGE_MASK, m);
    probe_vpn2 <= v;
    probe_tag <= 8'h11;
    bus_wr(REG_ENTRY_SEL, {26'h0, i});
    bus_wr(REG_CTRL, 32'h4);
  endtask

  task automatic t_reset();
    rd_chk("pointer", REG_REPLACE, {26'h0, TOP_ENTRY});
    rd_chk("limit", REG_PINNED, 32'h0);
    rd_chk("unmapped", 3'h4, 32'h0);
    rd_chk("control", REG_CTRL, 32'h0);
  endtask

  task automatic t_pointer();
    retire_n(3);
    rd_chk("decrement", REG_REPLACE, 32'h2C);
    bus_wr(REG_PINNED, 32'h2D);
    rd_chk("reload", REG_REPLACE, 32'h2F);
    rd_chk("limit rd", REG_PINNED, 32'h2D);
    retire_n(2);
    rd_chk("lower bound", REG_REPLACE, 32'h2D);
    retire_n(1);
    rd_chk("wrap", REG_REPLACE, 32'h2F);
  endtask

  task automatic t_regs();
    logic [31:0] m;
    bus_wr(REG_ENTRY_SEL, 32'h2A);
    rd_chk("select", REG_ENTRY_SEL, 32'h2A);
    bus_wr(REG_EVEN_LO, 32'h2AAAAAAA);
    bus_wr(REG_ODD_LO, 32'h15555555);
    rd_chk("even", REG_EVEN_LO, 32'h2AAAAAAA);
    rd_chk("odd", REG_ODD_LO, 32'h15555555);
    // only legal encodings written
    // All seven page sizes, ones paired upward from the low mask bit
    for (int k = 0; k < 7; k++) begin
      m = ((32'h1 << (2 * k)) - 32'h1) << MASK_LSB;
      bus_wr(REG_PAGE_MASK, m);
      rd_chk("mask", REG_PAGE_MASK, m);
    end
  endtask

  task automatic t_entry();
    logic [31:0] d;
    bus_wr(REG_EVEN_LO, 32'h0ABCDE03);
    bus_wr(REG_ODD_LO, 32'h01234501);
    put_entry(6'h05, 27'h0123456, 32'h0);
    bus_wr(REG_ENTRY_SEL, 32'h9);
    bus_wr(REG_CTRL, 32'h1);
    rd_chk("probe hit", REG_ENTRY_SEL, 32'h5);
    // Lookup tag differs from stored tag; global in both halves
    lookup(27'h0123456, 8'h77, 1'b0);
    chk_flag("global hit", 1'b1, look_hit);
    chk_word("frame", 32'h0ABCDE03, {2'b00, look_lo});
    lookup(27'h0123456, 8'h77, 1'b1);
    chk_flag("invalid miss", 1'b1, look_miss);
    chk_flag("invalid no hit", 1'b0, look_hit);
    // Wider page ignores the two low page bits
    put_entry(6'h06, 27'h0444440, 32'h6000);
    lookup(27'h0444443, 8'h77, 1'b0);
    chk_flag("mask hit", 1'b1, look_hit);
    // Global in one half only keeps the space tag in the compare
    bus_wr(REG_ODD_LO, 32'h01234502);
    put_entry(6'h07, 27'h0111111, 32'h0);
    lookup(27'h0111111, 8'h77, 1'b0);
    chk_flag("tag miss", 1'b1, look_miss);
    lookup(27'h0111111, 8'h11, 1'b1);
    chk_flag("tag hit", 1'b1, look_hit);
    chk_word("odd frame", 32'h01234502, {2'b00, look_lo});
    bus_wr(REG_EVEN_LO, 32'h0);
    bus_wr(REG_PAGE_MASK, 32'h1E000);
    bus_wr(REG_ENTRY_SEL, 32'h5);
    bus_wr(REG_CTRL, 32'h2);
    rd_chk("buffer read", REG_EVEN_LO, 32'h0ABCDE03);
    rd_chk("read odd", REG_ODD_LO, 32'h01234501);
    rd_chk("read mask", REG_PAGE_MASK, 32'h0);
    chk_word("read page", {5'h0, 27'h0123456}, {5'h0, read_vpn2});
    chk_word("read tag", 32'h11, {24'h0, read_tag});
    // Write aimed past the last entry must land nowhere
    put_entry(6'h32, 27'h00055AA, 32'h0);
    bus_wr(REG_CTRL, 32'h1);
    bus_rd(REG_ENTRY_SEL, d);
    chk_flag("probe fail", 1'b1, d[PROBE_FAIL_BIT]);
    chk_word("miss keeps select", 32'h80000032, d);
    // Buffer read past the last entry must leave the staging alone
    bus_wr(REG_EVEN_LO, 32'h0);
    bus_wr(REG_CTRL, 32'h2);
    rd_chk("no read past end", REG_EVEN_LO, 32'h0);
  endtask

  task automatic t_random();
    bus_wr(REG_PINNED, 32'h28);
    probe_vpn2 <= 27'h0333333;
    bus_wr(REG_CTRL, 32'h8);
    bus_wr(REG_ENTRY_SEL, 32'h0);
    bus_wr(REG_CTRL, 32'h1);
    rd_chk("random slot", REG_ENTRY_SEL, 32'h2F);
    // Two retires move the pointer; the next random write follows it
    retire_n(2);
    probe_vpn2 <= 27'h0222222;
    bus_wr(REG_CTRL, 32'h8);
    bus_wr(REG_CTRL, 32'h1);
    rd_chk("random moved", REG_ENTRY_SEL, 32'h2D);
  endtask

  // Stimulus: everything driven at time zero, reset for ten cycles
  initial begin
    bad_count = 0;
    n_tests = 0;
    rst_in = 1'b1;
    bus = '0;
    retire = 1'b0;
    probe_vpn2 = 27'h0;
    probe_tag = 8'h0;
    look_vpn2 = 27'h0;
    look_tag = 8'h0;
    look_odd = 1'b0;
    look_req = 1'b0;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_reset();
    t_pointer();
    t_regs();
    t_entry();
    t_random();
    print_verdict();
  end

  // Watchdog cuts a hang short
  initial begin
    #WATCHDOG_NS;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
